// ==== src/pzps_consts.svh ====
`ifndef PZPS_CONSTS_SVH
`define PZPS_CONSTS_SVH

// Clock and timing figures, reset values, select codes and the address base.
`define PZPS_CLK_MHZ          200
`define PZPS_SAMPLE_US        10
`define PZPS_SAMPLE_CYC       (`PZPS_SAMPLE_US * `PZPS_CLK_MHZ)
`define PZPS_DELAY_STEP_US    10
`define PZPS_DELAY_STEP_CYC   (`PZPS_DELAY_STEP_US * `PZPS_CLK_MHZ)
`define PZPS_DELAY_RST_US     200
`define PZPS_DELAY_RST        8'h14
`define PZPS_HYST_RST         8'h10
`define PZPS_THR_DISABLED     8'hFF
`define PZPS_PSI_LOW          2'h0
`define PZPS_PSI_MID          2'h1
`define PZPS_PSI_HIGH         2'h2
`define PZPS_ADDR_BASE        7'h20

`endif

// ==== src/pzps_if.sv ====
`timescale 1ns/1ps
// Zone request and the configuration the sequencer needs.
interface pzps_if;
    import pzps_pkg::*;
    pzps_zone_t  target;
    pzps_phase_t phases;
    logic [3:0]  zone_ok;
    logic [7:0]  delay_steps;
    pzps_zone_t  zone;
    logic        busy;
    modport req (output target, phases, zone_ok, delay_steps, input zone, busy);
    modport seq (input target, phases, zone_ok, delay_steps, output zone, busy);
endinterface : pzps_if

// ==== src/pzps_pkg.sv ====
package pzps_pkg;
    // Power zones used by the regulator; zone 1 does not exist.
    typedef enum logic [2:0] {
        PZPS_Z0 = 3'h0,
        PZPS_Z2 = 3'h2,
        PZPS_Z3 = 3'h3,
        PZPS_Z4 = 3'h4
    } pzps_zone_t;

    typedef enum logic [1:0] {
        PZPS_PH4 = 2'h0,
        PZPS_PH3 = 2'h1,
        PZPS_PH2 = 2'h2,
        PZPS_PH1 = 2'h3
    } pzps_phase_t;
endpackage : pzps_pkg

// ==== src/pzps_stepper.sv ====
`timescale 1ns/1ps
`include "pzps_consts.svh"
// Steps the current zone toward the target one zone at a time.
module pzps_stepper
    import pzps_pkg::*;
(
    input  wire logic clock,   // 200 MHz clock
    input  wire logic resetn,  // Async reset, active low
    pzps_if.seq       bus      // Target and configuration in, zone out
);
    typedef struct packed {
        pzps_zone_t  zone;
        logic [11:0] tick;
        logic [7:0]  steps;
        logic        wait_on;
    } pzps_step_t;

    pzps_step_t s_q;
    pzps_step_t s_d;

    // Next zone in a direction, skipping disabled zones; zone_ok bits map Z0,Z2,Z3,Z4.
    function automatic pzps_zone_t pzps_next(input pzps_zone_t z, input logic up, input logic [3:0] ok);
        pzps_zone_t n;
        n = z;
        if (up) begin
            if (z == PZPS_Z0 && ok[1]) n = PZPS_Z2;
            else if (z <= PZPS_Z2 && ok[2]) n = PZPS_Z3;
            else if (z <= PZPS_Z3) n = PZPS_Z4;
        end else begin
            if (z == PZPS_Z4 && ok[2]) n = PZPS_Z3;
            else if (z >= PZPS_Z3 && ok[1]) n = PZPS_Z2;
            else n = PZPS_Z0;
        end
        return n;
    endfunction : pzps_next

    // Moves toward zone 0 are immediate, moves toward zone 4 wait per step.
    always_comb begin
        s_d = s_q;
        if (bus.target < s_q.zone) begin
            s_d.zone    = pzps_next(s_q.zone, 1'b0, bus.zone_ok);
            s_d.wait_on = 1'b0;
        end else if (bus.target > s_q.zone) begin
            if (!s_q.wait_on) begin
                s_d.wait_on = 1'b1;
                s_d.steps   = bus.delay_steps;
                s_d.tick    = 12'h000;
            end else if (s_q.steps == 8'h00) begin
                s_d.zone    = pzps_next(s_q.zone, 1'b1, bus.zone_ok);
                s_d.wait_on = 1'b0;
            end else if (s_q.tick == 12'(`PZPS_DELAY_STEP_CYC - 1)) begin
                s_d.tick  = 12'h000;
                s_d.steps = s_q.steps - 8'h01;
            end else begin
                s_d.tick = s_q.tick + 12'h001;
            end
        end else begin
            s_d.wait_on = 1'b0;
        end
    end

    // State register; reset lands in zone 0.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{zone: PZPS_Z0, tick: 12'h000, steps: 8'h00, wait_on: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.zone = s_q.zone;
    assign bus.busy = s_q.wait_on;
endmodule : pzps_stepper

// ==== src/pzps_top.sv ====
`timescale 1ns/1ps
`include "pzps_consts.svh"
module pzps_top
    import pzps_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = `PZPS_SAMPLE_CYC  // Cycles between current samples
) (
    input  wire logic        clock,                  // 200 MHz clock
    input  wire logic        resetn,                 // Async power-up reset, active low
    input  wire logic        strap_valid,            // Strap measurements are ready
    input  wire logic [2:0]  load_line_address_strap,// Measured address strap code 0..7
    input  wire logic [2:0]  fixed_zone_strap,       // Measured fixed-zone code 0..4
    input  wire logic [3:0]  phase_sense_input,      // High where a phase is fitted
    input  wire logic [1:0]  power_saving_select,    // 0 low, 1 mid, 2 high
    input  wire logic        enable,                 // Regulator enable
    input  wire logic        vout_nominal,           // Output reached regulation
    input  wire logic [7:0]  total_current_monitor,  // Digitised total current
    input  wire logic [7:0]  phase_shed_threshold1,  // Threshold 1
    input  wire logic [7:0]  phase_shed_threshold2,  // Threshold 2
    input  wire logic [7:0]  phase_shed_threshold3,  // Threshold 3
    input  wire logic [7:0]  phase_shed_threshold4,  // Threshold 4
    input  wire logic        hyst_we,                // Hysteresis write strobe
    input  wire logic [7:0]  hyst_wdata,             // Hysteresis value
    input  wire logic        delay_we,               // Shed delay write strobe
    input  wire logic [7:0]  delay_wdata,            // Shed delay in 10 us steps
    input  wire logic        load_line_trim_we,      // Load-line trim write strobe
    input  wire logic [7:0]  load_line_trim_wdata,   // Load-line percentage
    input  wire logic        fixed_zone_we,          // Fixed zone write strobe
    input  wire logic [2:0]  fixed_zone_wdata,       // Fixed zone code 0..4
    output logic [6:0]       i2c_address,            // Decoded slave address
    output logic [7:0]       load_line_pct,          // Applied load-line percentage
    output logic [1:0]       phase_count,            // Phase configuration
    output logic [2:0]       power_zone,             // Current zone
    output logic [3:0]       phase_drive_out,        // Phase enables
    output logic             dcm_mode,               // Discontinuous conduction
    output logic             fsw_100k                // 100 kHz switching override
);
    initial begin
        if (SAMPLE_CYC < 2 || SAMPLE_CYC > 65535) $error("SAMPLE_CYC out of range");
    end

    typedef struct packed {
        logic        latched;
        logic [2:0]  addr_code;
        pzps_phase_t phases;
        logic [2:0]  fixed_code;
        logic [7:0]  ll_pct;
        logic [7:0]  hyst;
        logic [7:0]  delay;
        logic [1:0]  sel;
        logic        sel_lock;
        logic [15:0] sample_cnt;
        pzps_zone_t  auto_zone;
        logic [3:0]  outs;
        logic        dcm;
    } pzps_state_t;

    pzps_state_t st_q;
    pzps_state_t st_d;
    pzps_if      zif ();

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Strap code to fixed zone, taking the phase count into account.
    function automatic pzps_zone_t pzps_fixed(input logic [2:0] c, input pzps_phase_t p);
        pzps_zone_t z;
        z = PZPS_Z0;
        unique case (c)
            3'h0, 3'h1: z = PZPS_Z0;
            3'h2:       z = (p == PZPS_PH4) ? PZPS_Z2 : PZPS_Z0;
            3'h3:       z = (p == PZPS_PH1) ? PZPS_Z0 : PZPS_Z3;
            default:    z = PZPS_Z4;
        endcase
        return z;
    endfunction : pzps_fixed

    // Clamp a zone to those the phase count allows.
    function automatic pzps_zone_t pzps_clamp(input pzps_zone_t z, input pzps_phase_t p);
        pzps_zone_t r;
        r = z;
        if (z == PZPS_Z2 && p != PZPS_PH4) r = PZPS_Z0;
        if (z == PZPS_Z3 && p == PZPS_PH1) r = PZPS_Z0;
        return r;
    endfunction : pzps_clamp

    ////////////////////////////////////////////////////////////////////////////
    // Threshold comparison with hysteresis, one lane per threshold.
    logic [7:0] thr [4];
    logic [3:0] thr_on;
    logic [3:0] above;
    logic [3:0] below;

    assign thr[0] = phase_shed_threshold1;
    assign thr[1] = phase_shed_threshold2;
    assign thr[2] = phase_shed_threshold3;
    assign thr[3] = phase_shed_threshold4;

    for (genvar i = 0; i < 4; i++) begin : g_thr
        logic [8:0] low_edge;
        assign thr_on[i]   = (thr[i] != `PZPS_THR_DISABLED);
        assign low_edge    = {1'b0, thr[i]} - {1'b0, st_q.hyst};
        assign above[i]    = thr_on[i] && (total_current_monitor > thr[i]);
        assign below[i]    = !low_edge[8] && ({1'b0, total_current_monitor} < low_edge);
    end

    // Raw automatic target: the highest band whose threshold is crossed.
    pzps_zone_t cmp_zone;
    always_comb begin
        if (above[3] || above[2])      cmp_zone = PZPS_Z0;
        else if (above[1])             cmp_zone = PZPS_Z2;
        else if (above[0])             cmp_zone = PZPS_Z3;
        else                           cmp_zone = PZPS_Z4;
    end

    // Hysteresis: a move to a higher number needs current below threshold minus hysteresis.
    pzps_zone_t hyst_zone;
    always_comb begin
        hyst_zone = pzps_clamp(cmp_zone, st_q.phases);
        if (hyst_zone > st_q.auto_zone) begin
            unique case (st_q.auto_zone)
                PZPS_Z0: if (!(below[2] || !thr_on[2])) hyst_zone = st_q.auto_zone;
                PZPS_Z2: if (!(below[1] || !thr_on[1])) hyst_zone = st_q.auto_zone;
                PZPS_Z3: if (!(below[0] || !thr_on[0])) hyst_zone = st_q.auto_zone;
                PZPS_Z4: hyst_zone = st_q.auto_zone;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main state update.
    pzps_zone_t target;
    logic [3:0] zone_ok;

    always_comb begin
        st_d = st_q;
        // Straps are latched once after power-up.
        if (!st_q.latched && strap_valid) begin
            st_d.latched    = 1'b1;
            st_d.addr_code  = load_line_address_strap;
            st_d.fixed_code = fixed_zone_strap;
            st_d.ll_pct     = load_line_address_strap[0] ? 8'h00 : 8'h64;
            priority casez (phase_sense_input)
                4'b1111: st_d.phases = PZPS_PH4;
                4'b?111: st_d.phases = PZPS_PH3;
                4'b??11: st_d.phases = PZPS_PH2;
                default: st_d.phases = PZPS_PH1;
            endcase
        end
        if (load_line_trim_we) st_d.ll_pct = load_line_trim_wdata;
        if (hyst_we)           st_d.hyst   = hyst_wdata;
        if (delay_we)          st_d.delay  = delay_wdata;
        if (fixed_zone_we)     st_d.fixed_code = fixed_zone_wdata;
        // Select is frozen from enable until regulation is reached.
        if (!enable)                 st_d.sel_lock = 1'b1;
        else if (vout_nominal)       st_d.sel_lock = 1'b0;
        if (!(enable && st_q.sel_lock)) st_d.sel = power_saving_select;
        // Sample the current every 10 us in automatic mode.
        if (st_q.sel == `PZPS_PSI_MID) begin
            if (st_q.sample_cnt == 16'(SAMPLE_CYC - 1)) begin
                st_d.sample_cnt = 16'h0000;
                st_d.auto_zone  = hyst_zone;
            end else begin
                st_d.sample_cnt = st_q.sample_cnt + 16'h0001;
            end
        end else begin
            st_d.sample_cnt = 16'h0000;
            st_d.auto_zone  = zif.zone;
        end
        // Phase enables and conduction mode follow the stepped zone.
        unique case (zif.zone)
            PZPS_Z0: unique case (st_q.phases)
                PZPS_PH4: st_d.outs = 4'hF;
                PZPS_PH3: st_d.outs = 4'h7;
                PZPS_PH2: st_d.outs = 4'h3;
                PZPS_PH1: st_d.outs = 4'h1;
            endcase
            PZPS_Z2: st_d.outs = 4'h5;
            default: st_d.outs = 4'h1;
        endcase
        st_d.dcm = (zif.zone == PZPS_Z4);
    end

    // Target zone and enabled-zone mask for the stepper.
    always_comb begin
        zone_ok = {1'b1, thr_on[0], thr_on[1], 1'b1};
        if (st_q.phases != PZPS_PH4) zone_ok[1] = 1'b0;
        if (st_q.phases == PZPS_PH1) zone_ok[2] = 1'b0;
        unique case (st_q.sel)
            `PZPS_PSI_LOW: begin
                target = pzps_fixed(st_q.fixed_code, st_q.phases);
                if (target == PZPS_Z2) zone_ok[1] = 1'b1;
                if (target == PZPS_Z3) zone_ok[2] = 1'b1;
            end
            `PZPS_PSI_MID: target = st_q.auto_zone;
            default:       target = PZPS_Z0;
        endcase
    end

    assign zif.target      = target;
    assign zif.phases      = st_q.phases;
    assign zif.zone_ok     = zone_ok;
    assign zif.delay_steps = st_q.delay;

    pzps_stepper i_pzps_stepper (
        .clock  (clock),
        .resetn (resetn),
        .bus    (zif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State register; defaults until the straps are latched.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{latched: 1'b0, addr_code: 3'h0, phases: PZPS_PH4, fixed_code: 3'h0,
                      ll_pct: 8'h64, hyst: `PZPS_HYST_RST, delay: `PZPS_DELAY_RST,
                      sel: `PZPS_PSI_HIGH, sel_lock: 1'b1, sample_cnt: 16'h0000,
                      auto_zone: PZPS_Z0, outs: 4'hF, dcm: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs from state; the address is 0x20 plus 0x10 per code pair.
    assign i2c_address     = `PZPS_ADDR_BASE + {2'h0, st_q.addr_code[2:1], 3'h0} + {2'h0, st_q.addr_code[2:1], 3'h0};
    assign load_line_pct   = st_q.ll_pct;
    assign phase_count     = st_q.phases;
    assign power_zone      = zif.zone;
    assign phase_drive_out = st_q.outs;
    assign dcm_mode        = st_q.dcm;
    assign fsw_100k        = st_q.dcm;
endmodule : pzps_top

// ==== tb/pzps_chk.sv ====
`timescale 1ns/1ps
// Watches the zone, drive and configuration outputs of the zone controller.
module pzps_chk #(
    parameter int unsigned SAMPLE_CYC = 2000  // Cycles between current samples
) (
    input wire logic       clock,                // Core clock
    input wire logic       resetn,               // Async reset, active low
    input wire logic [1:0] power_saving_select,  // Select level
    input wire logic       enable,               // Regulator enable
    input wire logic       vout_nominal,         // Output in regulation
    input wire logic       load_line_trim_we,    // Trim write strobe
    input wire logic [7:0] load_line_trim_wdata, // Trim value
    input wire logic [6:0] i2c_address,          // Decoded address
    input wire logic [7:0] load_line_pct,        // Applied load line
    input wire logic [1:0] phase_count,          // Phase setup
    input wire logic [2:0] power_zone,           // Current zone
    input wire logic [3:0] phase_drive_out,      // Phase enables
    input wire logic       dcm_mode,             // Discontinuous mode
    input wire logic       fsw_100k              // Low frequency override
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // A zone counts as settled once it and the phase setup held for three edges,
    // since the drive register trails the zone by one cycle.
    sequence s_held(logic [2:0] z);
        (power_zone == z && $stable(phase_count))[*3];
    endsequence
    chk_reset_state: assert property ($rose(resetn) |-> power_zone == 3'h0 && phase_drive_out == 4'hF && !dcm_mode)
        else $error("zone outputs wrong after reset");
    chk_zone0_drive: assert property (s_held(3'h0) |-> phase_drive_out == (4'hF >> phase_count))
        else $error("zone 0 drive does not match phase setup");
    chk_zone2_drive: assert property (s_held(3'h2) |-> phase_drive_out == 4'h5)
        else $error("zone 2 drive wrong");
    chk_zone3_drive: assert property (s_held(3'h3) |-> phase_drive_out == 4'h1)
        else $error("zone 3 drive wrong");
    chk_zone4_light: assert property (s_held(3'h4) |-> phase_drive_out == 4'h1 && dcm_mode && fsw_100k)
        else $error("zone 4 drive or mode wrong");
    chk_ccm_mode: assert property ((power_zone != 3'h4)[*3] |-> !dcm_mode && !fsw_100k)
        else $error("discontinuous mode outside zone 4");
    chk_no_jump: assert property ($changed(power_zone) && phase_count != 2'h3 |->
        !((power_zone == 3'h4 && $past(power_zone) == 3'h0) || (power_zone == 3'h0 && $past(power_zone) == 3'h4)))
        else $error("zone jumped past intermediate zones");
    chk_high_zone0: assert property ((power_saving_select == 2'h2 && enable && vout_nominal)[*8] |-> power_zone == 3'h0)
        else $error("select high did not hold zone 0");
    chk_trim_write: assert property (load_line_trim_we |=> load_line_pct == $past(load_line_trim_wdata))
        else $error("trim write not applied");
    chk_addr_range: assert property (i2c_address inside {7'h20, 7'h30, 7'h40, 7'h50})
        else $error("slave address outside decoded set");
endmodule : pzps_chk

bind pzps_top pzps_chk #(.SAMPLE_CYC(SAMPLE_CYC)) i_pzps_chk (
    .clock(clock), .resetn(resetn), .power_saving_select(power_saving_select), .enable(enable),
    .vout_nominal(vout_nominal), .load_line_trim_we(load_line_trim_we), .load_line_trim_wdata(load_line_trim_wdata),
    .i2c_address(i2c_address), .load_line_pct(load_line_pct), .phase_count(phase_count), .power_zone(power_zone),
    .phase_drive_out(phase_drive_out), .dcm_mode(dcm_mode), .fsw_100k(fsw_100k));

// ==== tb/pzps_host.sv ====
`timescale 1ns/1ps
// Host side: drives select and enable, and stands in for the output ramp.
module pzps_host #(
    parameter int unsigned RAMP_CYC = 40  // Cycles from enable to regulation
) (
    input  wire logic       clock,               // Core clock
    input  wire logic       en_req,              // Bench wants the rail on
    input  wire logic [1:0] sel_req,             // Bench select level
    output logic [1:0]      power_saving_select, // Three-level select pin
    output logic            enable,              // Regulator enable
    output logic            vout_nominal         // Output in regulation
);
    logic [1:0]  sel_s;
    logic        en_s;
    int unsigned ramp_q;
    initial begin
        power_saving_select = 2'h2;
        enable = 1'b0;
        vout_nominal = 1'b0;
        ramp_q = 0;
    end
    // Requests are taken at the edge and pins move just after it; the ramp restarts when enable drops.
    always @(posedge clock) begin
        sel_s = sel_req;
        en_s = en_req;
        #1;
        power_saving_select = sel_s;
        enable = en_s;
        ramp_q = en_s ? ramp_q + 1 : 0;
        vout_nominal = en_s && (ramp_q >= RAMP_CYC);
    end
endmodule : pzps_host

// ==== tb/pzps_top_bench.sv ====
`timescale 1ns/1ps
// Directed checks of the zone controller through its strap and write ports.
module pzps_top_bench;
    localparam int unsigned SAMPLE = 20;  // Short sample period keeps the run brief
    logic       clock, resetn, strap_valid, en_req, enable, vout_nominal, dcm_mode, fsw_100k;
    logic       hyst_we, delay_we, load_line_trim_we, fixed_zone_we;
    logic [1:0] sel_req, power_saving_select, phase_count;
    logic [2:0] load_line_address_strap, fixed_zone_strap, fixed_zone_wdata, power_zone;
    logic [3:0] phase_sense_input, phase_drive_out;
    logic [6:0] i2c_address;
    logic [7:0] total_current_monitor, hyst_wdata, delay_wdata, load_line_trim_wdata, load_line_pct;
    logic [7:0] phase_shed_threshold1, phase_shed_threshold2, phase_shed_threshold3, phase_shed_threshold4;
    logic [2:0] fz [5] = '{3'h0, 3'h0, 3'h2, 3'h3, 3'h4};  // Fixed codes to zones, four phases
    int         errors, comparisons, hits;
    pzps_top #(.SAMPLE_CYC(SAMPLE)) i_pzps_top (
        .clock(clock), .resetn(resetn), .strap_valid(strap_valid), .load_line_address_strap(load_line_address_strap),
        .fixed_zone_strap(fixed_zone_strap), .phase_sense_input(phase_sense_input),
        .power_saving_select(power_saving_select), .enable(enable), .vout_nominal(vout_nominal),
        .total_current_monitor(total_current_monitor), .phase_shed_threshold1(phase_shed_threshold1),
        .phase_shed_threshold2(phase_shed_threshold2), .phase_shed_threshold3(phase_shed_threshold3),
        .phase_shed_threshold4(phase_shed_threshold4), .hyst_we(hyst_we), .hyst_wdata(hyst_wdata),
        .delay_we(delay_we), .delay_wdata(delay_wdata), .load_line_trim_we(load_line_trim_we),
        .load_line_trim_wdata(load_line_trim_wdata), .fixed_zone_we(fixed_zone_we), .fixed_zone_wdata(fixed_zone_wdata),
        .i2c_address(i2c_address), .load_line_pct(load_line_pct), .phase_count(phase_count), .power_zone(power_zone),
        .phase_drive_out(phase_drive_out), .dcm_mode(dcm_mode), .fsw_100k(fsw_100k));
    pzps_host i_pzps_host (.clock(clock), .en_req(en_req), .sel_req(sel_req),
        .power_saving_select(power_saving_select), .enable(enable), .vout_nominal(vout_nominal));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Every input moves one nanosecond after an edge, clear of the sampling instant.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Bounded wait for a zone; a hung sequencer shows up as a mismatch, not a stall.
    task automatic wait_zone(input logic [2:0] z, input int n);
        for (int k = 0; k < n && power_zone !== z; k++) tick(1);
        check({5'h0, power_zone}, {5'h0, z});
    endtask : wait_zone
    // One-cycle write strobe: 0 hysteresis, 1 shed delay, 2 load-line trim, 3 fixed zone.
    task automatic wr(input int which, input logic [7:0] d);
        hyst_wdata = d;
        delay_wdata = d;
        load_line_trim_wdata = d;
        fixed_zone_wdata = d[2:0];
        {hyst_we, delay_we, load_line_trim_we, fixed_zone_we} = 4'h8 >> which;
        tick(1);
        {hyst_we, delay_we, load_line_trim_we, fixed_zone_we} = 4'h0;
        tick(1);
    endtask : wr
    // Straps only latch once per reset, so each strap setting costs a reset.
    task automatic strap_reset(input logic [2:0] code, input logic [3:0] sense);
        resetn = 1'b0;
        strap_valid = 1'b0;
        load_line_address_strap = code;
        phase_sense_input = sense;
        tick(3);
        check({power_zone, phase_drive_out, dcm_mode}, 8'h1E);
        check(load_line_pct, 8'h64);
        check({i2c_address[5:0], phase_count}, {6'h20, 2'h0});
        resetn = 1'b1;
        tick(1);
        strap_valid = 1'b1;
        tick(3);
    endtask : strap_reset
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        errors = 0;
        comparisons = 0;
        resetn = 1'b0;
        strap_valid = 1'b0;
        load_line_address_strap = 3'h0;
        phase_sense_input = 4'hF;
        fixed_zone_strap = 3'h0;
        {hyst_we, delay_we, load_line_trim_we, fixed_zone_we} = 4'h0;
        {hyst_wdata, delay_wdata, load_line_trim_wdata, fixed_zone_wdata} = 27'h0;
        sel_req = 2'h2;
        en_req = 1'b1;
        total_current_monitor = 8'h10;
        {phase_shed_threshold1, phase_shed_threshold2} = 16'h4060;
        {phase_shed_threshold3, phase_shed_threshold4} = 16'h80A0;
        for (int i = 0; i < 8; i++) begin
            strap_reset(i[2:0], 4'hF >> i[1:0]);
            check({1'b0, i2c_address}, 8'h20 + 8'h10 * i[2:1]);
            check(load_line_pct, i[0] ? 8'h00 : 8'h64);
            check({6'h0, phase_count}, {6'h0, i[1:0]});
            check({4'h0, phase_drive_out}, {4'h0, 4'hF >> i[1:0]});
        end
        strap_reset(3'h0, 4'hF);
        wr(2, 8'h37);
        check(load_line_pct, 8'h37);
        // Automatic mode requested while the rail is still ramping up.
        // A zero shed delay makes a select that was not frozen climb to zone 4 inside the ramp.
        wr(1, 8'h00);
        en_req = 1'b0;
        tick(5);
        en_req = 1'b1;
        sel_req = 2'h1;
        tick(30);
        check({5'h0, power_zone}, 8'h00);
        wr(1, 8'h01);
        tick(1000);
        check({5'h0, power_zone}, 8'h00);
        wait_zone(3'h2, 1300);
        tick(1);
        check({4'h0, phase_drive_out}, 8'h05);
        wait_zone(3'h3, 2100);
        wait_zone(3'h4, 2100);
        tick(2);
        check({4'h0, phase_drive_out, 2'h0, dcm_mode, fsw_100k}, 8'h13);
        // A load step must bring the zone down without the shed delay.
        total_current_monitor = 8'hB0;
        wait_zone(3'h0, 40);
        wr(1, 8'h00);
        total_current_monitor = 8'h75;
        tick(100);
        check({5'h0, power_zone}, 8'h00);
        total_current_monitor = 8'h6F;
        wait_zone(3'h2, 60);
        wr(0, 8'h02);
        total_current_monitor = 8'h5D;
        wait_zone(3'h3, 60);
        // Fixed zone codes, stepped the same way as automatic mode.
        sel_req = 2'h0;
        for (int k = 0; k < 5; k++) begin
            wr(3, k[7:0]);
            wait_zone(fz[k], 60);
        end
        // Threshold 2 disabled: fixed mode still reaches zone 2, automatic mode steps past it.
        phase_shed_threshold2 = 8'hFF;
        wr(3, 8'h02);
        wait_zone(3'h2, 20);
        total_current_monitor = 8'hB0;
        sel_req = 2'h1;
        wait_zone(3'h0, 60);
        total_current_monitor = 8'h10;
        hits = 0;
        for (int k = 0; k < 80 && power_zone !== 3'h3; k++) begin
            tick(1);
            if (power_zone === 3'h2) hits++;
        end
        check(hits[7:0], 8'h00);
        wait_zone(3'h3, 0);
        sel_req = 2'h2;
        wait_zone(3'h0, 20);
        tick(2);
        check({4'h0, phase_drive_out}, 8'h0F);
        tally_and_finish();
    end
endmodule : pzps_top_bench
